// file: common/fge_pkg.sv
package fge_pkg;

	// Operation codes taken by this unit
	localparam logic [7:0] OPC_GEQ_BOOL  = 8'h92;
	localparam logic [7:0] OPC_GEQ_FLAGS = 8'h93;

	// Widths of the datapath
	localparam int WORD_W  = 32;
	localparam int FLAGS_W = 7;
	localparam int DEST_W  = 7;

	// Bit positions of the exception vector, same as the status word
	localparam int FLG_DIVIDE_BY_ZERO   = 0;
	localparam int FLG_INEXACT          = 1;
	localparam int FLG_UNDERFLOW        = 2;
	localparam int FLG_OVERFLOW         = 3;
	localparam int FLG_INVALID          = 4;
	localparam int FLG_INPUT_FLUSHED    = 5;
	localparam int FLG_OUTPUT_FLUSHED   = 6;

	// Guard bit that enables the write
	localparam int GUARD_BIT = 0;

	// Single-precision field layout
	localparam int FP_SIGN_BIT = 31;
	localparam int FP_EXP_HI   = 30;
	localparam int FP_EXP_LO   = 23;
	localparam int FP_MAN_HI   = 22;
	localparam logic [7:0] FP_EXP_MAX = 8'hff;
	localparam logic [7:0] FP_EXP_MIN = 8'h00;

	// Values after reset
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [6:0]  RST_FLAGS = 7'h00;
	localparam logic [6:0]  RST_DEST  = 7'h00;

	// Cycles from issue to result
	localparam int RESULT_LATENCY = 1;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_BOOL,
		KIND_FLAGS
	} fge_kind_e;

endpackage

// file: common/fge_cmp_if.sv
`timescale 1ns/1ps
interface fge_cmp_if;
	logic [31:0] op_a;
	logic [31:0] op_b;
	logic        ge;
	logic        nan_any;
	logic        flush_any;
	logic [6:0]  flags;

	modport cmp (
		input  op_a,
		input  op_b,
		output ge,
		output nan_any,
		output flush_any,
		output flags
	);
	modport user (
		output op_a,
		output op_b,
		input  ge,
		input  nan_any,
		input  flush_any,
		input  flags
	);
endinterface

// file: src/fge_cmp.sv
`timescale 1ns/1ps
// Pure combinational greater-or-equal on two single-precision words
module fge_cmp (
	fge_cmp_if.cmp c
);

	// Exponent all zero with a nonzero fraction
	function automatic logic is_denorm(input logic [31:0] v);
		is_denorm = (v[fge_pkg::FP_EXP_HI:fge_pkg::FP_EXP_LO]
			== fge_pkg::FP_EXP_MIN) && (v[fge_pkg::FP_MAN_HI:0] != 23'h0);
	endfunction

	// Exponent all ones with a nonzero fraction, quiet or signalling
	function automatic logic is_nan(input logic [31:0] v);
		is_nan = (v[fge_pkg::FP_EXP_HI:fge_pkg::FP_EXP_LO]
			== fge_pkg::FP_EXP_MAX) && (v[fge_pkg::FP_MAN_HI:0] != 23'h0);
	endfunction

	// Denormals become a zero of the same sign
	function automatic logic [31:0] flush(input logic [31:0] v);
		flush = is_denorm(v) ? {v[fge_pkg::FP_SIGN_BIT], 31'h0} : v;
	endfunction

	logic [31:0] a_f;
	logic [31:0] b_f;
	logic        a_neg;
	logic        b_neg;
	logic        both_zero;
	logic        mag_ge;
	logic        mag_le;
	logic        ord_ge;

	// Sign-magnitude order; +0 and -0 compare equal
	always_comb begin
		a_f       = flush(c.op_a);
		b_f       = flush(c.op_b);
		a_neg     = a_f[fge_pkg::FP_SIGN_BIT];
		b_neg     = b_f[fge_pkg::FP_SIGN_BIT];
		both_zero = (a_f[30:0] == 31'h0) && (b_f[30:0] == 31'h0);
		mag_ge    = a_f[30:0] >= b_f[30:0];
		mag_le    = a_f[30:0] <= b_f[30:0];
		if (both_zero) begin
			ord_ge = 1'b1;
		end else if (a_neg != b_neg) begin
			ord_ge = b_neg;
		end else begin
			ord_ge = a_neg ? mag_le : mag_ge;
		end
	end

	// Unordered compare is false and raises invalid
	always_comb begin
		c.nan_any   = is_nan(c.op_a) || is_nan(c.op_b);
		c.flush_any = is_denorm(c.op_a) || is_denorm(c.op_b);
		c.ge        = ord_ge && !c.nan_any;
		c.flags     = 7'h00;
		c.flags[fge_pkg::FLG_INVALID]       = c.nan_any;
		c.flags[fge_pkg::FLG_INPUT_FLUSHED] = c.flush_any;
	end

endmodule

// file: src/fge_unit.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1: Opcode 146 writes 1 to the destination when first >= second, else 0.
// RQ2: Both sources are single-precision floats and the result is an integer.
// RQ3: The boolean form flushes denormal inputs to zero and sets the flag.
// RQ4: Exceptions of the boolean compare set the matching status flags.
// RQ5: Status flags are sticky and only an explicit status write clears them.
// RQ6: Status flags update on the same edge as the boolean result is written.
// RQ7: Concurrent status updates are ORed together and with the old flags.
// RQ8: A clear guard LSB leaves both destination and status flags unchanged.
// RQ9: Opcode 147 writes the compare's exception vector to the destination.
// RQ10: The flags form never modifies the status-word flags.
// RQ11: The flags form flushes denormal inputs and sets bit 5 of the vector.
// RQ12: The vector uses the status layout, bits 31 down to 7 read as zero.
// RQ13: A NaN operand makes the boolean result 0 and raises invalid.
// RQ14: Results of either form appear one cycle after issue.
module fge_unit (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic        i_ce,
	input  wire logic        i_issue,
	input  wire logic [7:0]  i_opcode,
	input  wire logic [31:0] i_guard,
	input  wire logic [31:0] i_first_source,
	input  wire logic [31:0] i_second_source,
	input  wire logic [6:0]  i_dest,
	input  wire logic        i_ext_valid,
	input  wire logic [6:0]  i_ext_flags,
	input  wire logic        i_psw_wr,
	input  wire logic [6:0]  i_psw_wdata,
	output logic             o_wr_en,
	output logic [6:0]       o_wr_dest,
	output logic [31:0]      o_wr_data,
	output logic [6:0]       o_processor_status_word
);

	fge_cmp_if cmp_bus ();

	fge_cmp u_cmp (
		.c (cmp_bus.cmp)
	);

	// Operands go straight to the compare, no flush needed here
	assign cmp_bus.op_a = i_first_source; // RQ2
	assign cmp_bus.op_b = i_second_source;

	fge_pkg::fge_kind_e kind;
	logic               guard_ok;
	logic               fire;

	// Decode the issue slot; other opcodes belong to sibling units
	always_comb begin
		if (!i_issue) begin
			kind = fge_pkg::KIND_NONE;
		end else if (i_opcode == fge_pkg::OPC_GEQ_BOOL) begin
			kind = fge_pkg::KIND_BOOL;
		end else if (i_opcode == fge_pkg::OPC_GEQ_FLAGS) begin
			kind = fge_pkg::KIND_FLAGS;
		end else begin
			kind = fge_pkg::KIND_NONE;
		end
		guard_ok = i_guard[fge_pkg::GUARD_BIT]; // RQ8
		fire     = guard_ok && (kind != fge_pkg::KIND_NONE); // RQ8
	end

	logic        wr_en_r;
	logic        wr_en_nxt;
	logic [6:0]  dest_r;
	logic [6:0]  dest_nxt;
	logic [31:0] data_r;
	logic [31:0] data_nxt;
	logic [6:0]  psw_r;
	logic [6:0]  psw_nxt;

	// Result path; data holds its last value when nothing fires
	always_comb begin
		wr_en_nxt = 1'b0;
		dest_nxt  = dest_r;
		data_nxt  = data_r;
		if (fire) begin
			wr_en_nxt = 1'b1; // RQ14
			dest_nxt  = i_dest;
			case (kind)
				fge_pkg::KIND_BOOL: begin
					data_nxt = {31'h0, cmp_bus.ge}; // RQ1 RQ13
				end
				fge_pkg::KIND_FLAGS: begin
					data_nxt = {25'h0, cmp_bus.flags}; // RQ9 RQ11 RQ12
				end
				default: begin
					data_nxt = data_r;
				end
			endcase
		end
	end

	// Status flags: an explicit write loads, then every set is ORed on
	// top so a set arriving with the clearing write is never lost
	always_comb begin
		psw_nxt = psw_r; // RQ5
		if (i_psw_wr) begin
			psw_nxt = i_psw_wdata;
		end
		if (i_ext_valid) begin
			psw_nxt = psw_nxt | i_ext_flags; // RQ7
		end
		// Only the boolean form touches the status word
		if (fire && (kind == fge_pkg::KIND_BOOL)) begin
			psw_nxt = psw_nxt | cmp_bus.flags; // RQ3 RQ4 RQ6 RQ10
		end
	end

	// Single register stage; clock enable freezes everything except reset
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			wr_en_r <= 1'b0;
			dest_r  <= fge_pkg::RST_DEST;
			data_r  <= fge_pkg::RST_WORD;
			psw_r   <= fge_pkg::RST_FLAGS;
		end else if (i_ce) begin
			wr_en_r <= wr_en_nxt;
			dest_r  <= dest_nxt;
			data_r  <= data_nxt;
			psw_r   <= psw_nxt; // RQ6
		end
	end

	// Outputs straight from the flops
	assign o_wr_en                 = wr_en_r;
	assign o_wr_dest               = dest_r;
	assign o_wr_data               = data_r;
	assign o_processor_status_word = psw_r;

	// Checks on issue-to-writeback, status word, reset and clock enable
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);

	// Boolean result lands one cycle later with the compare's value
	AST_BOOL_RESULT: assert property ( // RQ1
		(i_ce && fire && kind == fge_pkg::KIND_BOOL)
		|=> (o_wr_en && o_wr_data == {31'h0, $past(cmp_bus.ge)}
			&& o_wr_dest == $past(i_dest))
	) else $error("boolean result wrong or late");

	// Known order: 3.0 >= 1.0 must give one
	AST_KNOWN_ORDER: assert property ( // RQ2
		(i_ce && fire && kind == fge_pkg::KIND_BOOL
			&& i_first_source == 32'h4040_0000
			&& i_second_source == 32'h3f80_0000)
		|=> (o_wr_data == 32'h0000_0001)
	) else $error("3.0 >= 1.0 did not give one");

	// Denormal input in the boolean form raises input-flushed
	AST_BOOL_FLUSH: assert property ( // RQ3
		(i_ce && fire && kind == fge_pkg::KIND_BOOL && cmp_bus.flush_any)
		|=> o_processor_status_word[fge_pkg::FLG_INPUT_FLUSHED]
	) else $error("flush flag not raised by boolean form");

	// Compare exceptions reach the status word on the write edge
	AST_BOOL_EXC: assert property ( // RQ4
		(i_ce && fire && kind == fge_pkg::KIND_BOOL)
		|=> ((o_processor_status_word & $past(cmp_bus.flags))
			== $past(cmp_bus.flags)) && o_wr_en
	) else $error("compare exceptions missing from status");

	// Without an explicit write no set flag ever drops
	AST_STICKY: assert property ( // RQ5
		(i_ce && !i_psw_wr)
		|=> ((o_processor_status_word & $past(o_processor_status_word))
			== $past(o_processor_status_word))
	) else $error("sticky flag cleared without status write");

	// Concurrent updates show, with or without an explicit write
	AST_OR_MERGE: assert property ( // RQ7
		(i_ce && i_ext_valid)
		|=> ((o_processor_status_word & $past(i_ext_flags))
			== $past(i_ext_flags))
	) else $error("concurrent status update lost");

	// Clear guard: no write, status untouched by this unit
	AST_GUARD_OFF: assert property ( // RQ8
		(i_ce && kind != fge_pkg::KIND_NONE && !guard_ok
			&& !i_ext_valid && !i_psw_wr)
		|=> (!o_wr_en && $stable(o_processor_status_word)
			&& $stable(o_wr_data))
	) else $error("guarded-off operation changed state");

	// Flags form writes the vector and leaves the status word alone
	AST_FLAGS_VEC: assert property ( // RQ9
		(i_ce && fire && kind == fge_pkg::KIND_FLAGS
			&& !i_ext_valid && !i_psw_wr)
		|=> (o_wr_en && o_wr_data == {25'h0, $past(cmp_bus.flags)}
			&& $stable(o_processor_status_word)) // RQ10
	) else $error("flags form result or status wrong");

	// Vector layout: upper bits zero, flush in bit 5
	AST_FLAGS_LAYOUT: assert property ( // RQ12
		(i_ce && fire && kind == fge_pkg::KIND_FLAGS)
		|=> (o_wr_data[31:7] == 25'h0
			&& o_wr_data[fge_pkg::FLG_INPUT_FLUSHED]
				== $past(cmp_bus.flush_any)) // RQ11
	) else $error("flags vector layout wrong");

	// NaN operand: false result and invalid set
	AST_NAN: assert property ( // RQ13
		(i_ce && fire && kind == fge_pkg::KIND_BOOL && cmp_bus.nan_any)
		|=> (o_wr_data == 32'h0
			&& o_processor_status_word[fge_pkg::FLG_INVALID])
	) else $error("NaN compare not false or invalid missing");

	// Write strobe only follows a guarded issue
	AST_LATENCY: assert property ( // RQ14
		(i_ce && !fire) |=> !o_wr_en
	) else $error("write strobe without a guarded issue");

	// Reset empties every output on the next edge, enable or not
	AST_RESET_CLEAR: assert property ( // RQ5
		disable iff (1'b0)
		!i_resetn |=> (!o_wr_en
			&& o_wr_dest == fge_pkg::RST_DEST
			&& o_wr_data == fge_pkg::RST_WORD
			&& o_processor_status_word == fge_pkg::RST_FLAGS)
	) else $error("outputs not cleared by reset");

	// Low enable freezes all state; the strobe stretches, not repeats
	AST_CE_FREEZE: assert property ( // RQ14
		!i_ce |=> ($stable(o_wr_en) && $stable(o_wr_dest)
			&& $stable(o_wr_data)
			&& $stable(o_processor_status_word))
	) else $error("state moved while clock enable low");

	// Every write echoes the destination index of its own issue
	AST_DEST_ECHO: assert property ( // RQ9
		(i_ce && fire)
		|=> (o_wr_en && o_wr_dest == $past(i_dest))
	) else $error("destination index not echoed");

	// Without a write the result and index keep their last value
	AST_DATA_HOLD: assert property ( // RQ8
		(i_ce && !fire)
		|=> ($stable(o_wr_data) && $stable(o_wr_dest))
	) else $error("result changed without a write");

	// Opcodes of sibling units never reach this unit's writeback
	AST_FOREIGN_OPC: assert property ( // RQ1
		(i_ce && i_issue && i_opcode != fge_pkg::OPC_GEQ_BOOL
			&& i_opcode != fge_pkg::OPC_GEQ_FLAGS)
		|=> (!o_wr_en && $stable(o_wr_data))
	) else $error("foreign opcode wrote a result");

	// An explicit write with no concurrent set loads the value as is
	AST_PSW_LOAD: assert property ( // RQ5
		(i_ce && i_psw_wr && !i_ext_valid && !i_issue)
		|=> (o_processor_status_word == $past(i_psw_wdata))
	) else $error("explicit status write not loaded");

	// No write, no foreign set, no boolean issue: status stands
	AST_PSW_QUIET: assert property ( // RQ10
		(i_ce && !i_psw_wr && !i_ext_valid
			&& !(i_issue && i_opcode == fge_pkg::OPC_GEQ_BOOL))
		|=> $stable(o_processor_status_word)
	) else $error("status word changed with no source");

	// Equal operands compare true
	AST_EQUAL_TRUE: assert property ( // RQ1
		(i_ce && fire && kind == fge_pkg::KIND_BOOL
			&& i_first_source == 32'h4040_0000
			&& i_second_source == 32'h4040_0000)
		|=> (o_wr_data == 32'h0000_0001)
	) else $error("3.0 >= 3.0 did not give one");

	// Smaller first operand compares false
	AST_LESS_FALSE: assert property ( // RQ1
		(i_ce && fire && kind == fge_pkg::KIND_BOOL
			&& i_first_source == 32'h3f80_0000
			&& i_second_source == 32'h4040_0000)
		|=> (o_wr_data == 32'h0000_0000)
	) else $error("1.0 >= 3.0 did not give zero");

	// Opposite infinities keep their order
	AST_INF_ORDER: assert property ( // RQ2
		(i_ce && fire && kind == fge_pkg::KIND_BOOL
			&& i_first_source == 32'h7f80_0000
			&& i_second_source == 32'hff80_0000)
		|=> (o_wr_data == 32'h0000_0001)
	) else $error("+inf >= -inf did not give one");

	// A denormal second operand is flushed, so 1.0 stays above it
	AST_DENORM_TRUE: assert property ( // RQ3
		(i_ce && fire && kind == fge_pkg::KIND_BOOL
			&& i_first_source == 32'h3f80_0000
			&& i_second_source == 32'h0040_0000)
		|=> (o_wr_data == 32'h0000_0001)
	) else $error("1.0 >= denormal did not give one");

	// Flags form on a denormal: input-flushed alone
	AST_FLAGS_DENORM: assert property ( // RQ11
		(i_ce && fire && kind == fge_pkg::KIND_FLAGS
			&& i_first_source == 32'h3f80_0000
			&& i_second_source == 32'h0040_0000)
		|=> (o_wr_data == 32'h0000_0020)
	) else $error("flags of a denormal compare wrong");

	// Flags form on a NaN: invalid alone
	AST_FLAGS_NAN: assert property ( // RQ12
		(i_ce && fire && kind == fge_pkg::KIND_FLAGS
			&& i_first_source == 32'h4040_0000
			&& i_second_source == 32'h7fc0_0000)
		|=> (o_wr_data == 32'h0000_0010)
	) else $error("flags of a NaN compare wrong");

endmodule

// file: bench/fge_rf_model.sv
`timescale 1ns/1ps
// Register file of the issuing core, catches every write of the unit
module fge_rf_model (
	input wire logic        i_mclk,
	input wire logic        i_wr_en,
	input wire logic [6:0]  i_wr_dest,
	input wire logic [31:0] i_wr_data
);
	logic [31:0] regs [128];

	// Write lands on the edge after the unit raises its strobe
	always @(posedge i_mclk) begin
		if (i_wr_en === 1'b1)
			regs[i_wr_dest] <= i_wr_data;
	end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
	logic        i_mclk = 0;
	logic        i_resetn = 0;
	logic        i_ce = 1;
	logic        i_issue = 0;
	logic [7:0]  i_opcode = 8'h00;
	logic [31:0] i_guard = 32'h0;
	logic [31:0] i_first_source = 32'h0;
	logic [31:0] i_second_source = 32'h0;
	logic [6:0]  i_dest = 7'h00;
	logic        i_ext_valid = 0;
	logic [6:0]  i_ext_flags = 7'h00;
	logic        i_psw_wr = 0;
	logic [6:0]  i_psw_wdata = 7'h00;
	logic        o_wr_en;
	logic [6:0]  o_wr_dest;
	logic [31:0] o_wr_data;
	logic [6:0]  o_psw;
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;
	// Operand table: 3,0 / 3,3 / 1,3 / 3,1 / +inf,-inf / 1,den / inf / NaN
	logic [31:0] ta [8] = '{32'h40400000, 32'h40400000, 32'h3f800000,
		32'h40400000, 32'h7f800000, 32'h3f800000, 32'h7f800000, 32'h40400000};
	logic [31:0] tb [8] = '{32'h0, 32'h40400000, 32'h40400000, 32'h3f800000,
		32'hff800000, 32'h00400000, 32'h7f800000, 32'h7fc00000};
	logic        tg [8] = '{1, 1, 0, 1, 1, 1, 1, 0};
	logic [6:0]  tf [8] = '{0, 0, 0, 0, 0, 7'h20, 0, 7'h10};

	fge_unit dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce),
		.i_issue(i_issue), .i_opcode(i_opcode), .i_guard(i_guard),
		.i_first_source(i_first_source), .i_second_source(i_second_source),
		.i_dest(i_dest), .i_ext_valid(i_ext_valid), .i_ext_flags(i_ext_flags),
		.i_psw_wr(i_psw_wr), .i_psw_wdata(i_psw_wdata), .o_wr_en(o_wr_en),
		.o_wr_dest(o_wr_dest), .o_wr_data(o_wr_data),
		.o_processor_status_word(o_psw));
	fge_rf_model rf (.i_mclk(i_mclk), .i_wr_en(o_wr_en),
		.i_wr_dest(o_wr_dest), .i_wr_data(o_wr_data));

	always #10 i_mclk = ~i_mclk;

	// Hang guard, the whole run needs well under a thousand cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
	end

	// Idle cycle, then one issue cycle; returns with the answer settled.
	// The idle cycle keeps the strobe from rising as it falls.
	task automatic op(input logic [7:0] c, input logic [31:0] g, a, b,
		input logic [6:0] d);
		@(negedge i_mclk);
		i_issue = 1;
		i_opcode = c;
		i_guard = g;
		i_first_source = a;
		i_second_source = b;
		i_dest = d;
		@(negedge i_mclk);
		i_issue = 0;
	endtask

	// Explicit status write
	task automatic psw(input logic [6:0] v);
		i_psw_wr = 1;
		i_psw_wdata = v;
		@(negedge i_mclk);
		i_psw_wr = 0;
	endtask

	task automatic t_bool();
		for (int i = 0; i < 8; i++) begin
			psw(7'h00);
			op(8'h92, 32'h1, ta[i], tb[i], 7'(i + 1));
			`CHK("wr_en", 1'b1, o_wr_en)
			`CHK("wr_dest", 7'(i + 1), o_wr_dest)
			`CHK("wr_data", {31'h0, tg[i]}, o_wr_data)
			`CHK("status", tf[i], o_psw)
			@(negedge i_mclk);
			`CHK("wr_en low", 1'b0, o_wr_en)
			`CHK("rf", {31'h0, tg[i]}, rf.regs[i + 1])
		end
		$display("test bool done");
	endtask

	task automatic t_flags();
		psw(7'h41);
		for (int i = 0; i < 8; i++) begin
			op(8'h93, 32'h3, ta[i], tb[i], 7'h40);
			`CHK("flags en", 1'b1, o_wr_en)
			`CHK("flags", {25'h0, tf[i]}, o_wr_data)
			`CHK("status kept", 7'h41, o_psw)
		end
		op(8'h93, 32'h1, 32'h00400000, 32'h0, 7'h41);
		`CHK("den flags", 32'h20, o_wr_data)
		$display("test flags done");
	endtask

	task automatic t_guard();
		psw(7'h00);
		op(8'h92, 32'hfffffffe, ta[7], tb[7], 7'h11);
		`CHK("guard bool", 1'b0, o_wr_en)
		`CHK("guard psw", 7'h00, o_psw)
		op(8'h93, 32'h2, ta[5], tb[5], 7'h12);
		`CHK("guard flags", 1'b0, o_wr_en)
		`CHK("data held", 32'h20, o_wr_data)
		op(8'h91, 32'h1, ta[7], tb[7], 7'h13);
		`CHK("other opc", 1'b0, o_wr_en)
		`CHK("other psw", 7'h00, o_psw)
		i_ce = 0;
		op(8'h92, 32'h1, ta[7], tb[7], 7'h14);
		`CHK("ce psw", 7'h00, o_psw)
		`CHK("ce data", 32'h20, o_wr_data)
		i_ce = 1;
		$display("test guard done");
	endtask

	task automatic t_or();
		i_psw_wr = 1;
		i_ext_valid = 1;
		i_ext_flags = 7'h0c;
		op(8'h92, 32'h1, ta[7], tb[7], 7'h20);
		i_psw_wr = 0;
		i_ext_flags = 7'h40;
		`CHK("or merge", 7'h1c, o_psw)
		op(8'h92, 32'h1, ta[0], tb[0], 7'h21);
		i_ext_valid = 0;
		`CHK("sticky", 7'h5c, o_psw)
		@(negedge i_mclk);
		`CHK("sticky hold", 7'h5c, o_psw)
		psw(7'h00);
		`CHK("cleared", 7'h00, o_psw)
		$display("test or done");
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge i_mclk);
		i_resetn = 1;
		`CHK("reset psw", 7'h00, o_psw)
		`CHK("reset en", 1'b0, o_wr_en)
		t_bool();
		t_flags();
		t_guard();
		t_or();
		print_verdict();
	end
endmodule
